// ===== logic/ape_port_ctrl.sv
// Drive port start-up, enable polling, pin release and bus power sensing
//
// Contract
// - Address and selects float, then high after 2ms
// - Poll port enable every 20ms unless test
// - Enable high means normal drive interface operation
// - Enable low floats all drive pins
// - Enable low halts drive state machine
// - Chip reset clears everything; held about 10ms
// - Bus power input means host supply present
// - Sample bus power at start, every 20ms
// - Bus power high attaches pull-up, low releases
// - Enable falling disconnects and enters low power
`timescale 1ns/1ps
module ape_port_ctrl
    import ape_pkg::*;
#(
    parameter int STARTUP_CYCLES = APE_STARTUP_CYC,
    parameter int POLL_CYCLES = APE_POLL_CYC,
    parameter int DATA_W = APE_DATA_W
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic mfg_test_mode,
    input wire logic drive_port_enable,
    input wire logic bus_power_present,
    input wire logic [2:0] core_addr,
    input wire logic [1:0] core_select_n,
    input wire logic [2:0] core_ctrl_n,
    input wire logic core_drive_reset_n,
    input wire logic [DATA_W-1:0] core_data_out,
    input wire logic core_data_oe,
    input wire logic [DATA_W-1:0] drive_data_i,
    output logic [DATA_W-1:0] core_data_in,
    output logic drive_fsm_run,
    output logic usb_pullup_attach,
    output logic usb_low_power,
    output logic usb_rejoin,
    output logic drive_addr_bit0_o,
    output logic drive_addr_bit0_oe,
    output logic drive_addr_bit1_o,
    output logic drive_addr_bit1_oe,
    output logic drive_addr_bit2_o,
    output logic drive_addr_bit2_oe,
    output logic drive_select_n_first_o,
    output logic drive_select_n_first_oe,
    output logic drive_select_n_second_o,
    output logic drive_select_n_second_oe,
    output logic [2:0] drive_ctrl_n_o,
    output logic drive_ctrl_n_oe,
    output logic drive_reset_n_o,
    output logic drive_reset_n_oe,
    output logic [DATA_W-1:0] drive_data_o,
    output logic drive_data_oe
);
    localparam int SW = $clog2(STARTUP_CYCLES + 1);

    ape_state_t state_reg;
    ape_state_t state_next;
    logic [SW-1:0] start_cnt_reg;
    logic [SW-1:0] start_cnt_next;
    logic startup_done_reg;
    logic startup_done_next;
    logic low_power_reg;
    logic low_power_next;
    logic rejoin_reg;
    logic rejoin_next;
    logic pullup_reg;
    logic pullup_next;
    logic en_run;
    logic en_tick;
    logic vb_tick;
    logic en_poll;
    logic vb_poll;

    // Pin and core-side output registers
    logic [2:0] addr_reg;
    logic [2:0] addr_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    logic as_oe_reg;
    logic as_oe_next;
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    logic ctrl_oe_reg;
    logic ctrl_oe_next;
    logic dres_reg;
    logic dres_next;
    logic dres_oe_reg;
    logic dres_oe_next;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] dout_next;
    logic dout_oe_reg;
    logic dout_oe_next;
    logic [DATA_W-1:0] din_reg;
    logic [DATA_W-1:0] din_next;
    logic run_reg;
    logic run_next;

    // Enable polling only starts once the start-up delay is over
    assign en_run = startup_done_reg & ~mfg_test_mode;
    assign en_poll = en_tick & ce & ~mfg_test_mode;
    assign vb_poll = vb_tick & ce;

    ape_tick #(.PERIOD(POLL_CYCLES)) u_en_tick (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .run(en_run),
        .tick(en_tick)
    );

    // Bus power timer runs from reset, so its first sample is at start-up
    ape_tick #(.PERIOD(POLL_CYCLES)) u_vb_tick (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .run(1'b1),
        .tick(vb_tick)
    );

    always_comb begin
        state_next = state_reg;
        start_cnt_next = start_cnt_reg;
        startup_done_next = startup_done_reg;
        low_power_next = low_power_reg;
        rejoin_next = 1'b0;
        pullup_next = pullup_reg;
        if (!startup_done_reg) begin
            if (start_cnt_reg == SW'(STARTUP_CYCLES - 1)) begin
                startup_done_next = 1'b1;
            end else begin
                start_cnt_next = start_cnt_reg + 1'b1;
            end
        end
        unique case (state_reg)
            APE_ST_START: begin
                if (mfg_test_mode && startup_done_reg) begin
                    state_next = APE_ST_ON;
                end else if (en_poll) begin
                    state_next = drive_port_enable ? APE_ST_ON : APE_ST_OFF;
                end
            end
            APE_ST_OFF: begin
                if (en_poll && drive_port_enable) begin
                    state_next = APE_ST_ON;
                end
            end
            APE_ST_ON: begin
                if (en_poll && !drive_port_enable) begin
                    state_next = APE_ST_OFF;
                end
            end
        endcase
        if (en_poll) begin
            low_power_next = ~drive_port_enable;
            rejoin_next = drive_port_enable & low_power_reg;
        end
        if (vb_poll) begin
            pullup_next = bus_power_present;
        end
    end

    // Pins follow the state of the previous cycle; outputs stay flop-driven
    always_comb begin
        addr_next = {3{APE_PIN_IDLE}};
        sel_next = {2{APE_PIN_IDLE}};
        as_oe_next = 1'b0;
        ctrl_next = {3{APE_PIN_IDLE}};
        ctrl_oe_next = 1'b0;
        dres_next = APE_PIN_IDLE;
        dres_oe_next = 1'b0;
        dout_next = core_data_out;
        dout_oe_next = 1'b0;
        din_next = din_reg;
        run_next = 1'b0;
        unique case (state_reg)
            APE_ST_START: begin
                ctrl_oe_next = 1'b1;
            end
            APE_ST_OFF: begin
                as_oe_next = 1'b0;
            end
            APE_ST_ON: begin
                as_oe_next = 1'b1;
                ctrl_oe_next = 1'b1;
                dres_oe_next = 1'b1;
                // Test mode keeps the drive idle with lines parked high
                if (!mfg_test_mode) begin
                    addr_next = core_addr;
                    sel_next = core_select_n;
                    ctrl_next = core_ctrl_n;
                    dres_next = core_drive_reset_n;
                    dout_oe_next = core_data_oe;
                    din_next = drive_data_i;
                    run_next = 1'b1;
                end
            end
        endcase
    end

    // Asynchronous reset puts the whole block in its start-up state
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= APE_ST_START;
            start_cnt_reg <= '0;
            startup_done_reg <= APE_FLAG_RST;
            low_power_reg <= APE_FLAG_RST;
            rejoin_reg <= APE_FLAG_RST;
            pullup_reg <= APE_FLAG_RST;
            addr_reg <= {3{APE_PIN_IDLE}};
            sel_reg <= {2{APE_PIN_IDLE}};
            as_oe_reg <= APE_OE_RST;
            ctrl_reg <= {3{APE_PIN_IDLE}};
            ctrl_oe_reg <= APE_OE_RST;
            dres_reg <= APE_PIN_IDLE;
            dres_oe_reg <= APE_OE_RST;
            dout_reg <= '0;
            dout_oe_reg <= APE_OE_RST;
            din_reg <= '0;
            run_reg <= APE_FLAG_RST;
        end else if (ce) begin
            state_reg <= state_next;
            start_cnt_reg <= start_cnt_next;
            startup_done_reg <= startup_done_next;
            low_power_reg <= low_power_next;
            rejoin_reg <= rejoin_next;
            pullup_reg <= pullup_next;
            addr_reg <= addr_next;
            sel_reg <= sel_next;
            as_oe_reg <= as_oe_next;
            ctrl_reg <= ctrl_next;
            ctrl_oe_reg <= ctrl_oe_next;
            dres_reg <= dres_next;
            dres_oe_reg <= dres_oe_next;
            dout_reg <= dout_next;
            dout_oe_reg <= dout_oe_next;
            din_reg <= din_next;
            run_reg <= run_next;
        end
    end

    assign drive_addr_bit0_o = addr_reg[0];
    assign drive_addr_bit1_o = addr_reg[1];
    assign drive_addr_bit2_o = addr_reg[2];
    assign drive_addr_bit0_oe = as_oe_reg;
    assign drive_addr_bit1_oe = as_oe_reg;
    assign drive_addr_bit2_oe = as_oe_reg;
    assign drive_select_n_first_o = sel_reg[0];
    assign drive_select_n_second_o = sel_reg[1];
    assign drive_select_n_first_oe = as_oe_reg;
    assign drive_select_n_second_oe = as_oe_reg;
    assign drive_ctrl_n_o = ctrl_reg;
    assign drive_ctrl_n_oe = ctrl_oe_reg;
    assign drive_reset_n_o = dres_reg;
    assign drive_reset_n_oe = dres_oe_reg;
    assign drive_data_o = dout_reg;
    assign drive_data_oe = dout_oe_reg;
    assign core_data_in = din_reg;
    assign drive_fsm_run = run_reg;
    assign usb_pullup_attach = pullup_reg;
    assign usb_low_power = low_power_reg;
    assign usb_rejoin = rejoin_reg;

    // Helper: ce cycles between two enable samples
    logic [31:0] gap_reg;
    logic gap_ok_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg <= '0;
            gap_ok_reg <= 1'b0;
        end else if (ce) begin
            if (!en_run) begin
                gap_ok_reg <= 1'b0;
            end else if (en_tick) begin
                gap_reg <= 32'h1;
                gap_ok_reg <= 1'b1;
            end else begin
                gap_reg <= gap_reg + 32'h1;
            end
        end
    end

    sequence s_poll_low;
        en_poll && !drive_port_enable;
    endsequence
    sequence s_floating;
        !as_oe_reg && !ctrl_oe_reg && !dres_oe_reg && !dout_oe_reg;
    endsequence

    property p_start_float;
        @(posedge mclk) disable iff (!arst_n)
        (state_reg == APE_ST_START && ce) |=> !as_oe_reg;
    endproperty
    a_start_float: assert property (p_start_float)
        else $error("address or select driven during start-up");

    property p_test_high;
        @(posedge mclk) disable iff (!arst_n)
        (state_reg == APE_ST_ON && mfg_test_mode && ce) |=>
            (as_oe_reg && addr_reg == 3'h7 && sel_reg == 2'h3);
    endproperty
    a_test_high: assert property (p_test_high)
        else $error("address or select not driven high after start-up");

    property p_poll_gap;
        @(posedge mclk) disable iff (!arst_n)
        (en_tick && ce && gap_ok_reg && en_run) |->
            gap_reg == 32'(POLL_CYCLES);
    endproperty
    a_poll_gap: assert property (p_poll_gap)
        else $error("enable sample spacing wrong");

    property p_no_poll_test;
        @(posedge mclk) disable iff (!arst_n)
        (mfg_test_mode && ce) |=> !en_tick;
    endproperty
    a_no_poll_test: assert property (p_no_poll_test)
        else $error("enable polled in test mode");

    property p_enable_on_state;
        @(posedge mclk) disable iff (!arst_n)
        (en_poll && drive_port_enable) |=> state_reg == APE_ST_ON;
    endproperty
    a_enable_on_state: assert property (p_enable_on_state)
        else $error("port not enabled after high sample");

    property p_off_float;
        @(posedge mclk) disable iff (!arst_n)
        s_poll_low ##1 (ce && state_reg == APE_ST_OFF) |=> s_floating;
    endproperty
    a_off_float: assert property (p_off_float)
        else $error("drive pins driven while port disabled");

    property p_halt;
        @(posedge mclk) disable iff (!arst_n)
        (state_reg != APE_ST_ON && ce) |=> !run_reg;
    endproperty
    a_halt: assert property (p_halt)
        else $error("drive state machine runs while disabled");

    property p_pullup;
        @(posedge mclk) disable iff (!arst_n)
        vb_poll |=> usb_pullup_attach == $past(bus_power_present);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up does not follow bus power sample");

    property p_pullup_hold;
        @(posedge mclk) disable iff (!arst_n)
        !vb_poll |=> $stable(usb_pullup_attach);
    endproperty
    a_pullup_hold: assert property (p_pullup_hold)
        else $error("pull-up changed between bus power samples");

    property p_low_power;
        @(posedge mclk) disable iff (!arst_n)
        s_poll_low |=> usb_low_power && state_reg != APE_ST_ON;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("no low power after enable fell");

    property p_drive_reset;
        @(posedge mclk) disable iff (!arst_n)
        (state_reg == APE_ST_ON && !mfg_test_mode && ce) |=>
            (dres_oe_reg && dres_reg == $past(core_drive_reset_n));
    endproperty
    a_drive_reset: assert property (p_drive_reset)
        else $error("drive reset output does not follow request");
endmodule

// ===== logic/ape_pkg.sv
// Constants and types shared by the drive port start-up and enable logic
package ape_pkg;
    localparam int APE_CLK_HZ = 200_000_000;
    localparam int APE_STARTUP_MS = 2;
    localparam int APE_POLL_MS = 20;
    localparam int APE_STARTUP_CYC = (APE_CLK_HZ / 1000) * APE_STARTUP_MS;
    localparam int APE_POLL_CYC = (APE_CLK_HZ / 1000) * APE_POLL_MS;
    localparam int APE_DATA_W = 16;
    localparam logic APE_PIN_IDLE = 1'h1;
    localparam logic APE_OE_RST = 1'h0;
    localparam logic APE_FLAG_RST = 1'h0;

    typedef enum logic [2:0] {
        APE_ST_START = 3'h1,
        APE_ST_OFF = 3'h2,
        APE_ST_ON = 3'h4
    } ape_state_t;
endpackage

// ===== logic/ape_tick.sv
// Periodic sample strobe: fires when run is first seen, then every PERIOD
`timescale 1ns/1ps
module ape_tick
    import ape_pkg::*;
#(
    parameter int PERIOD = APE_POLL_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic run,
    output logic tick
);
    localparam int CW = $clog2(PERIOD + 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (!run) begin
            cnt_next = '0;
        end else if (cnt_reg == '0) begin
            tick_next = 1'b1;
            cnt_next = CW'(PERIOD - 1);
        end else begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    // The strobe holds while ce is low, so users qualify it with ce
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// ===== test/ape_drive_model.sv
// Behavioural attached drive sharing the data lines with the port
`timescale 1ns/1ps
module ape_drive_model (
    input wire logic mclk,
    input wire logic host_oe,
    input wire logic [15:0] host_data,
    output logic [15:0] bus
);
    logic [15:0] pat_reg = 16'h5A3C;

    // A released bus shows a moving pattern so a stale value cannot pass
    always_ff @(posedge mclk) begin
        pat_reg <= {pat_reg[14:0], ~(pat_reg[15] ^ pat_reg[4])};
    end

    // The drive only answers on lines the host has let go
    always_comb begin
        bus = host_oe ? host_data : pat_reg;
    end
endmodule

// ===== test/tb.sv
// Self-checking bench for the drive port start-up and enable logic
`timescale 1ns/1ps
module tb;
    import ape_pkg::*;
    localparam int SU = 20;
    localparam int PC = 50;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic tm = 1'b0;
    logic en = 1'b1;
    logic bp = 1'b1;
    logic [2:0] c_addr = 3'h7;
    logic [1:0] c_sel = 2'h3;
    logic [2:0] c_ctrl = 3'h7;
    logic c_rst = 1'b1;
    logic [15:0] c_dout = 16'h0000;
    logic c_doe = 1'b0;
    logic [15:0] d_in, c_din, d_out, d_prev;
    logic run, pu, lp, rj, a0, a0e, a1, a1e, a2, a2e;
    logic s0, s0e, s1, s1e, ctl_oe, r, roe, doe;
    logic [2:0] ctl;
    logic [3:0] exp_q[$];
    logic [3:0] obs;
    logic [3:0] obs_last = 4'h0;
    logic [9:0] exp_pins;
    logic [15:0] exp_dout;
    logic [31:0] lfsr = 32'h1B74C0AB;
    logic watch = 1'b1;
    logic rnd_on = 1'b0;
    logic ce_rnd = 1'b0;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int run_cnt = 0;
    int rejoins = 0;
    int t_rel, t_oe, t_lp1, t_lp0;

    ape_port_ctrl #(.STARTUP_CYCLES(SU), .POLL_CYCLES(PC)) u_ape_port_ctrl (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .mfg_test_mode(tm),
        .drive_port_enable(en), .bus_power_present(bp),
        .core_addr(c_addr), .core_select_n(c_sel), .core_ctrl_n(c_ctrl),
        .core_drive_reset_n(c_rst), .core_data_out(c_dout),
        .core_data_oe(c_doe), .drive_data_i(d_in), .core_data_in(c_din),
        .drive_fsm_run(run), .usb_pullup_attach(pu), .usb_low_power(lp),
        .usb_rejoin(rj), .drive_addr_bit0_o(a0), .drive_addr_bit0_oe(a0e),
        .drive_addr_bit1_o(a1), .drive_addr_bit1_oe(a1e),
        .drive_addr_bit2_o(a2), .drive_addr_bit2_oe(a2e),
        .drive_select_n_first_o(s0), .drive_select_n_first_oe(s0e),
        .drive_select_n_second_o(s1), .drive_select_n_second_oe(s1e),
        .drive_ctrl_n_o(ctl), .drive_ctrl_n_oe(ctl_oe),
        .drive_reset_n_o(r), .drive_reset_n_oe(roe),
        .drive_data_o(d_out), .drive_data_oe(doe));

    ape_drive_model u_ape_drive_model (
        .mclk(mclk), .host_oe(doe), .host_data(d_out), .bus(d_in));

    assign obs = {a0e, run, lp, pu};

    always #2.5 mclk = ~mclk;

    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %0h exp %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Bounded wait until every noted state change has been seen
    task automatic settle(input string name);
        int k;
        for (k = 0; k < 4 * PC && exp_q.size() != 0; k++) begin
            @(negedge mclk);
        end
        check(exp_q.size(), 0, "noted change never came");
        $display("test %s done", name);
    endtask

    // Watcher: takes the oldest note whenever the state outputs move
    always @(posedge mclk) begin
        cyc++;
        // Expected pins follow the core values of the last enabled edge
        if (ce) begin
            d_prev <= d_in;
            exp_pins <= {c_addr, c_sel, c_ctrl, c_rst, c_doe};
            exp_dout <= c_dout;
        end
        if (cyc > 5000) begin
            fails++;
            close_out();
        end
        #1;
        run_cnt = run ? run_cnt + 1 : 0;
        if (rj === 1'b1) rejoins++;
        if (watch && obs !== obs_last) begin
            if (a0e === 1'b1 && obs_last[3] !== 1'b1) t_oe = cyc;
            if (lp === 1'b1 && obs_last[1] !== 1'b1) t_lp1 = cyc;
            if (lp === 1'b0 && obs_last[1] === 1'b1) t_lp0 = cyc;
            if (exp_q.size() == 0) begin
                check(obs, ~obs, "unexpected state change");
            end else begin
                check(obs, exp_q.pop_front(), "state outputs");
            end
        end
        obs_last = obs;
    end

    // Pin copy and read path checked while steadily enabled, then new stimulus
    always @(negedge mclk) begin
        if (run === 1'b1 && lp === 1'b0 && run_cnt >= 3) begin
            check({a2, a1, a0, s1, s0, ctl, r, doe},
                  exp_pins, "pins");
            check(c_din, d_prev, "read data");
            if (exp_pins[0] === 1'b1) check(d_out, exp_dout, "write data");
        end
        if (rnd_on) begin
            lfsr = lfsr_step(lfsr);
            c_addr = lfsr[2:0];
            c_sel = lfsr[4:3];
            c_ctrl = lfsr[7:5];
            c_rst = lfsr[8];
            c_dout = lfsr[24:9];
            c_doe = lfsr[25];
        end
        // Random stalls show that a low clock enable freezes the copy path
        ce = ce_rnd ? lfsr[26] : 1'b1;
    end

    initial begin
        repeat (6) @(negedge mclk);
        check({a0, a1, a2, s0, s1, a0e, s1e}, 7'h7C, "parked pins");
        exp_q.push_back(4'b0001);
        exp_q.push_back(4'b1101);
        arst_n = 1'b1;
        t_rel = cyc;
        settle("startup");
        check((t_oe - t_rel >= SU) && (t_oe - t_rel <= SU + 6), 1, "delay");
        check({a0, a1, a2, s0, s1}, 5'h1F, "pins high");
        rnd_on = 1'b1;
        ce_rnd = 1'b1;
        repeat (30) @(negedge mclk);
        ce_rnd = 1'b0;
        @(negedge mclk);
        exp_q.push_back(4'b1111);
        exp_q.push_back(4'b0011);
        en = 1'b0;
        settle("disable");
        check({a1e, a2e, s0e, s1e, ctl_oe, roe, doe}, 0, "released");
        repeat (PC / 3) @(negedge mclk);
        exp_q.push_back(4'b0001);
        exp_q.push_back(4'b1101);
        en = 1'b1;
        settle("enable");
        check((t_lp0 - t_lp1) % PC, 0, "poll period");
        check(rejoins, 1, "rejoin");
        repeat (40) @(negedge mclk);
        exp_q.push_back(4'b1100);
        bp = 1'b0;
        settle("bus power low");
        exp_q.push_back(4'b1101);
        bp = 1'b1;
        settle("bus power high");
        watch = 1'b0;
        arst_n = 1'b0;
        tm = 1'b1;
        en = 1'b0;
        #1;
        check({a0e, s0e, ctl_oe, roe, doe, run, pu}, 0, "chip reset");
        repeat (6) @(negedge mclk);
        arst_n = 1'b1;
        repeat (SU + 3 * PC) @(negedge mclk);
        check({run, lp}, 2'h0, "test mode ignores enable");
        $display("test reset and test mode done");
        close_out();
    end
endmodule
